// File: design/swp_top.sv
// write burst capture and precharge logic of the memory device
module swp_top #(
    parameter int DQ_W = 8,
    parameter int QDEPTH = 4
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CK,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [swp_pkg::BA_W-1:0] BA,
    input wire logic [swp_pkg::ADDR_W-1:0] A,
    input wire logic DQS_I,
    output logic DQS_O,
    output logic DQS_OE_N,
    input wire logic [DQ_W-1:0] DQ_I,
    output logic [DQ_W-1:0] DQ_O,
    output logic [DQ_W-1:0] DQ_OE_N,
    input wire logic [DQ_W/8-1:0] DM
);

    localparam int DM_W = DQ_W / 8;
    localparam int PW = $clog2(QDEPTH);
    localparam int MA_W = swp_pkg::BA_W + swp_pkg::COL_W;
    localparam int CW = swp_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    swp_pkg::swp_cmd_t cmd_s1_q, cmd_s2_q;
    logic ck_s1_q, ck_s2_q, ck_prev_q;
    logic dqs_s1_q, dqs_s2_q, dqs_prev_q;
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q;
    logic [DM_W-1:0] dm_s1_q, dm_s2_q;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cmd_s1_q <= '0;
            cmd_s2_q <= '0;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_prev_q <= 1'b0;
            dqs_s1_q <= 1'b0;
            dqs_s2_q <= 1'b0;
            dqs_prev_q <= 1'b0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            dm_s1_q <= '0;
            dm_s2_q <= '0;
        end
        else
        begin
            cmd_s1_q <= '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N, ba: BA, a: A};
            cmd_s2_q <= cmd_s1_q;
            ck_s1_q <= CK;
            ck_s2_q <= ck_s1_q;
            ck_prev_q <= ck_s2_q;
            dqs_s1_q <= DQS_I;
            dqs_s2_q <= dqs_s1_q;
            dqs_prev_q <= dqs_s2_q;
            dq_s1_q <= DQ_I;
            dq_s2_q <= dq_s1_q;
            dm_s1_q <= DM;
            dm_s2_q <= dm_s1_q;
        end
    end

    logic ck_rise, dqs_rise, dqs_fall;
    logic [3:0] cmd_code;

    assign ck_rise = ck_s2_q & ~ck_prev_q;
    assign dqs_rise = dqs_s2_q & ~dqs_prev_q;
    assign dqs_fall = ~dqs_s2_q & dqs_prev_q;
    assign cmd_code = {cmd_s2_q.cs_n, cmd_s2_q.ras_n, cmd_s2_q.cas_n, cmd_s2_q.we_n};

    ////////////////////////////////////////////////////////////////////////////
    // register file state
    logic [31:0] cfg_q, cfg_d;
    logic [MA_W-1:0] mem_addr_q, mem_addr_d;
    logic aph_valid_q, aph_valid_d;
    logic aph_write_q, aph_write_d;
    logic [7:0] aph_addr_q, aph_addr_d;

    logic [1:0] bl_mode;
    logic [4:0] wl;

    assign bl_mode = cfg_q[swp_pkg::CFG_BL_LSB +: 2];
    assign wl = {1'b0, cfg_q[swp_pkg::CFG_AL_LSB +: 4]} + {1'b0, cfg_q[swp_pkg::CFG_CWL_LSB +: 4]};

    ////////////////////////////////////////////////////////////////////////////
    // burst engine state
    swp_pkg::swp_state_t state_q, state_d;
    logic [2:0] idx_q, idx_d;
    swp_pkg::swp_burst_t q_q [QDEPTH];
    swp_pkg::swp_burst_t q_d [QDEPTH];
    logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [PW:0] cnt_q, cnt_d;
    logic [swp_pkg::NBANK-1:0] bank_q, bank_d;
    logic [CW-1:0] ckc_q, ckc_d;
    logic we_q, we_d;
    logic [MA_W-1:0] waddr_q, waddr_d;
    logic [DQ_W-1:0] wdata_q, wdata_d;
    logic [DM_W-1:0] wmask_q, wmask_d;
    logic [15:0] wrc_q, wrc_d;

    swp_pkg::swp_burst_t head, nxt;
    logic [CW-1:0] head_diff, nxt_diff;
    logic head_ready, nxt_ready, capture, last, push, pop, bc4;
    logic [swp_pkg::COL_W-1:0] col_elem;

    assign head = q_q[rd_q];
    assign nxt = q_q[PW'(rd_q + 1'b1)];
    assign head_diff = ckc_q - head.due;
    assign nxt_diff = ckc_q - nxt.due;
    assign head_ready = (cnt_q != '0) && !head_diff[CW-1];
    assign nxt_ready = (cnt_q > (PW+1)'(1)) && !nxt_diff[CW-1];
    assign capture = ((state_q == swp_pkg::ST_BURST) && (dqs_rise || dqs_fall))
                   || ((state_q == swp_pkg::ST_ARMED) && dqs_rise);
    assign last = (idx_q == (head.bc4 ? swp_pkg::LAST4 : swp_pkg::LAST8));
    assign col_elem = head.bc4
        ? {head.col[swp_pkg::COL_W-1:2], head.col[1:0] + idx_q[1:0]}
        : {head.col[swp_pkg::COL_W-1:3], head.col[2:0] + idx_q};
    assign bc4 = (bl_mode == swp_pkg::BL_FIX4)
               || ((bl_mode == swp_pkg::BL_OTF) && !cmd_s2_q.a[swp_pkg::A_BL]);

    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        q_d = q_q;
        rd_d = rd_q;
        wr_d = wr_q;
        bank_d = bank_q;
        ckc_d = ckc_q;
        we_d = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wmask_d = wmask_q;
        wrc_d = wrc_q;
        push = 1'b0;
        pop = 1'b0;
        // no edge is captured outside an armed or running burst; in idle a falling edge arms a due burst
        unique case (state_q)
            swp_pkg::ST_IDLE:
            begin
                if (head_ready && dqs_fall)
                begin
                    state_d = swp_pkg::ST_ARMED;
                end
            end
            swp_pkg::ST_ARMED, swp_pkg::ST_BURST:
            begin
                if (capture)
                begin
                    we_d = 1'b1;
                    waddr_d = {head.bank, col_elem};
                    wdata_d = dq_s2_q;
                    wmask_d = dm_s2_q;
                    idx_d = idx_q + 3'h1;
                    state_d = swp_pkg::ST_BURST;
                    if (last)
                    begin
                        pop = 1'b1;
                        rd_d = rd_q + 1'b1;
                        idx_d = 3'h0;
                        wrc_d = wrc_q + 16'h0001;
                        state_d = nxt_ready ? swp_pkg::ST_ARMED : swp_pkg::ST_IDLE;
                        if (head.ap)
                        begin
                            bank_d[head.bank] = 1'b0;
                        end
                    end
                end
            end
        endcase
        if (ck_rise)
        begin
            ckc_d = ckc_q + 1'b1;
            if (cmd_code == swp_pkg::CMD_WRITE && cnt_q != (PW+1)'(QDEPTH))
            begin
                push = 1'b1;
                wr_d = wr_q + 1'b1;
                q_d[wr_q] = '{due: ckc_q + CW'(wl), bank: cmd_s2_q.ba,
                    col: cmd_s2_q.a[swp_pkg::COL_W-1:0], bc4: bc4,
                    ap: cmd_s2_q.a[swp_pkg::A_AP]};
            end
            else if (cmd_code == swp_pkg::CMD_PRE)
            begin
                if (cmd_s2_q.a[swp_pkg::A_AP])
                begin
                    bank_d = '0;
                end
                else
                begin
                    bank_d[cmd_s2_q.ba] = 1'b0;
                end
            end
            else if (cmd_code == swp_pkg::CMD_ACT)
            begin
                bank_d[cmd_s2_q.ba] = 1'b1;
            end
        end
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_q <= swp_pkg::ST_IDLE;
            idx_q <= 3'h0;
            for (int i = 0; i < QDEPTH; i++)
            begin
                q_q[i] <= '0;
            end
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            bank_q <= '0;
            ckc_q <= '0;
            we_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wmask_q <= '0;
            wrc_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            q_q <= q_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            bank_q <= bank_d;
            ckc_q <= ckc_d;
            we_q <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wmask_q <= wmask_d;
            wrc_q <= wrc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data store
    logic [DQ_W-1:0] mem_rdata;

    swp_mem #(
        .DATA_W(DQ_W),
        .AW(MA_W)
    ) u_mem (
        .clk(CLK),
        .rst_n(RESET_N),
        .wr_en(we_q),
        .wr_addr(waddr_q),
        .wr_data(wdata_q),
        .wr_mask(wmask_q),
        .rd_addr(mem_addr_q),
        .rd_data(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    always_comb
    begin
        cfg_d = cfg_q;
        mem_addr_d = mem_addr_q;
        aph_valid_d = HSEL && HTRANS[1] && HREADY;
        aph_write_d = HWRITE;
        aph_addr_d = HADDR[7:0];
        if (aph_valid_q && aph_write_q)
        begin
            if (aph_addr_q == swp_pkg::OFS_CFG)
            begin
                cfg_d = HWDATA;
            end
            else if (aph_addr_q == swp_pkg::OFS_MEM_ADDR)
            begin
                mem_addr_d = HWDATA[MA_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cfg_q <= swp_pkg::CFG_RST;
            mem_addr_q <= '0;
            aph_valid_q <= 1'b0;
            aph_write_q <= 1'b0;
            aph_addr_q <= 8'h00;
        end
        else
        begin
            cfg_q <= cfg_d;
            mem_addr_q <= mem_addr_d;
            aph_valid_q <= aph_valid_d;
            aph_write_q <= aph_write_d;
            aph_addr_q <= aph_addr_d;
        end
    end

    always_comb
    begin
        HRDATA = 32'h0000_0000;
        if (aph_valid_q && !aph_write_q)
        begin
            unique case (aph_addr_q)
                swp_pkg::OFS_CFG: HRDATA = cfg_q;
                swp_pkg::OFS_STATUS: HRDATA = {16'h0000, 4'(cnt_q), 3'h0,
                    (state_q != swp_pkg::ST_IDLE), bank_q};
                swp_pkg::OFS_MEM_ADDR: HRDATA = 32'(mem_addr_q);
                swp_pkg::OFS_MEM_DATA: HRDATA = 32'(mem_rdata);
                swp_pkg::OFS_WR_COUNT: HRDATA = {16'h0000, wrc_q};
                default: HRDATA = 32'h0000_0000;
            endcase
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // the device never drives strobe or data on the write path
    assign DQS_O = 1'b0;
    assign DQS_OE_N = 1'b1;
    assign DQ_O = '0;
    assign DQ_OE_N = '1;

endmodule

// File: design/swp_pkg.sv
// shared constants and types of the write and precharge path
package swp_pkg;

    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam int COL_W = 10;
    localparam int CNT_W = 16;
    localparam int NBANK = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h08;
    localparam logic [7:0] OFS_MEM_DATA = 8'h0c;
    localparam logic [7:0] OFS_WR_COUNT = 8'h10;

    // config fields
    localparam int CFG_BL_LSB = 0;
    localparam int CFG_AL_LSB = 4;
    localparam int CFG_CWL_LSB = 8;
    localparam logic [31:0] CFG_RST = 32'h0000_0500;

    // burst length field codes
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;

    // last element index per burst length
    localparam logic [2:0] LAST8 = 3'h7;
    localparam logic [2:0] LAST4 = 3'h3;

    // address bit roles
    localparam int A_AP = 10;
    localparam int A_BL = 12;

    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_BURST = 3'b100
    } swp_state_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] a;
    } swp_cmd_t;

    // due holds the clock count one cycle before the first data edge
    typedef struct packed {
        logic [CNT_W-1:0] due;
        logic [BA_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic bc4;
        logic ap;
    } swp_burst_t;

endpackage

// File: design/swp_mem.sv
// write data store with byte mask and registered read port
module swp_mem #(
    parameter int DATA_W = 8,
    parameter int AW = 13
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W/8-1:0] wr_mask,
    input wire logic [AW-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    localparam int NB = DATA_W / 8;

    logic [DATA_W-1:0] rd_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // one store per byte lane, a high mask bit keeps the old byte
    genvar g;
    generate
        for (g = 0; g < NB; g++)
        begin : g_lane
            logic [7:0] lane [0:(1<<AW)-1];

            always_ff @(posedge clk)
            begin
                if (wr_en && !wr_mask[g])
                begin
                    lane[wr_addr] <= wr_data[g*8 +: 8];
                end
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    rd_data_q[g*8 +: 8] <= 8'h00;
                end
                else
                begin
                    rd_data_q[g*8 +: 8] <= lane[rd_addr];
                end
            end
        end
    endgenerate

    assign rd_data = rd_data_q;

endmodule

// File: tb/swp_top_monitor.sv
// assertion checker on the top ports of the write and precharge path
module swp_top_monitor #(
    parameter int DQ_W = 8
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic DQS_O,
    input wire logic DQS_OE_N,
    input wire logic [DQ_W-1:0] DQ_O,
    input wire logic [DQ_W-1:0] DQ_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_q;
    logic rd_d;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////
    // read data phase tracker
    always_comb rd_d = HSEL && HTRANS[1] && HREADY && !HWRITE;
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rd_q <= 1'b0;
        else
            rd_q <= rd_d;
    end
    ////////////////////////////////////////
    ready_high_a: assert property (HREADYOUT) else $error("hreadyout low");
    resp_okay_a: assert property (!HRESP) else $error("error response");
    idle_rdata_a: assert property (!rd_q |-> HRDATA == 32'h0) else $error("stray hrdata");
    wr_rdata_a: assert property (HSEL && HTRANS[1] && HWRITE ##1 1'b1 |-> HRDATA == 32'h0)
        else $error("hrdata in write phase");
    dq_hiz_a: assert property (&DQ_OE_N) else $error("dq driven");
    dqs_hiz_a: assert property (DQS_OE_N) else $error("dqs driven");
    dq_quiet_a: assert property (DQ_O == '0) else $error("dq output set");
    dqs_quiet_a: assert property ($stable(DQS_O) && !DQS_O) else $error("dqs output set");
endmodule

bind swp_top swp_top_monitor #(.DQ_W(DQ_W)) u_mon (
    .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .DQS_O(DQS_O), .DQS_OE_N(DQS_OE_N), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N)
);

// File: tb/swp_ctl_model.sv
// behavioural memory controller: free clock, commands and write strobe
module swp_ctl_model (
    output logic ck,
    output swp_pkg::swp_cmd_t c,
    output logic dqs,
    output logic [7:0] dq,
    output logic dm
);
    timeunit 1ns;
    timeprecision 1ps;
    int wl = 5;
    initial
    begin
        c = {4'h7, 3'h0, 14'h0};
        dqs = 1'b1;
        dq = 8'h00;
        dm = 1'b0;
        ck = 1'b0;
        forever #160 ck = ~ck;
    end
    ////////////////////////////////////////
    // one command at the next rising clock, then a hostile nop
    task automatic cmd(input logic [3:0] op, input logic [2:0] b, input logic [13:0] ad);
        @(negedge ck);
        c = {op, b, ad};
        @(negedge ck);
        c = {4'h7, ~b, ~ad};
    endtask
    // nb writes spaced four clocks apart with one gapless data stream
    task automatic wr(input logic [2:0] b, input logic [9:0] col, input logic ap, input logic a12,
        input int nb, input int nel, input logic [7:0] d [16], input logic m [16]);
        fork
            for (int k = 0; k < nb; k++)
            begin
                cmd(swp_pkg::CMD_WRITE, b, 14'(col + 10'(8 * k)) | 14'(ap) << swp_pkg::A_AP
                    | 14'(a12) << swp_pkg::A_BL);
                repeat (2) @(negedge ck);
            end
            begin
                @(negedge ck);
                repeat (wl) @(posedge ck);
                dqs = 1'b1;
                #160 dqs = 1'b0;
                for (int e = 0; e < nel; e++)
                begin
                    #80 dq = d[e];
                    dm = m[e];
                    #80 dqs = ~dqs;
                end
                #80 dq = ~dq;
                dm = ~dm;
                #80 dqs = 1'b1;
            end
        join
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the write burst and precharge path
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic en; logic [31:0] v;} swp_note_t;
    logic CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd_last;
    logic [1:0] HTRANS;
    wire logic HREADY;
    logic ck, dqs, dqs_o, dqs_oe_n, dm;
    logic [7:0] dq, dq_o, dq_oe_n;
    wire logic dqs_w;
    wire logic [7:0] dq_w;
    swp_pkg::swp_cmd_t cmd;
    logic [7:0] em [8192];
    swp_note_t q [$];
    swp_note_t nt;
    logic rd_dp = 1'b0;
    int err_total = 0;
    int checked = 0;
    int wcount = 0;
    assign HREADY = HREADYOUT;
    assign dqs_w = dqs_oe_n ? dqs : dqs_o;
    assign dq_w = (dq_oe_n & dq) | (~dq_oe_n & dq_o);
    swp_ctl_model u_ctl (.ck(ck), .c(cmd), .dqs(dqs), .dq(dq), .dm(dm));
    swp_top i_swp_top (
        .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CK(ck), .CS_N(cmd.cs_n), .RAS_N(cmd.ras_n),
        .CAS_N(cmd.cas_n), .WE_N(cmd.we_n), .BA(cmd.ba), .A(cmd.a), .DQS_I(dqs_w),
        .DQS_O(dqs_o), .DQS_OE_N(dqs_oe_n), .DQ_I(dq_w), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n),
        .DM(dm)
    );
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    ////////////////////////////////////////
    // result watcher: pops the oldest note at each read data phase and compares it when enabled
    always @(posedge CLK)
        rd_dp <= HSEL && HTRANS[1] && HREADY && !HWRITE;
    always @(negedge CLK)
    begin
        if (rd_dp === 1'b1)
        begin
            nt = q.pop_front();
            rd_last = HRDATA;
            if (nt.en)
            begin
                checked++;
                if (HRDATA !== nt.v)
                begin
                    err_total++;
                    $display("[FAIL] %s expected %h seen %h", nt.nm, nt.v, HRDATA);
                end
            end
        end
    end
    ////////////////////////////////////////
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, ad};
        do @(posedge CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADY !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic en, input string nm);
        q.push_back('{nm, en, e});
        bus(1'b0, ad, $urandom);
    endtask
    // one write stream; notes expected memory, count and stored bytes
    task automatic burst(input logic [2:0] b, input logic [9:0] col, input logic ap,
        input logic a12, input int nb, input int nel, input int len, input logic mk);
        logic [7:0] d [16];
        logic m [16];
        logic [9:0] cb;
        logic [9:0] ca;
        int n;
        for (int e = 0; e < 16; e++)
        begin
            d[e] = 8'($urandom);
            m[e] = mk & 1'($urandom);
            cb = col + 10'(8 * (e / 8));
            ca = (cb & ~10'(len - 1)) | ((cb + 10'(e % 8)) & 10'(len - 1));
            if (e < nel && e / 8 < nb && e % 8 < len && !m[e])
                em[{b, ca}] = d[e];
        end
        wcount += nb;
        u_ctl.wr(b, col, ap, a12, nb, nel, d, m);
        n = 0;
        do
        begin
            rd(swp_pkg::OFS_STATUS, 32'h0, 1'b0, "");
            n++;
        end while (rd_last[15:8] !== 8'h00 && n < 40);
        if (rd_last[15:8] !== 8'h00)
        begin
            err_total++;
            $display("[FAIL] engine idle expected 00 seen %h", rd_last[15:8]);
        end
        rd(swp_pkg::OFS_WR_COUNT, 32'(wcount), 1'b1, "wr_count");
        for (int e = 0; e < nb * 8; e++)
        begin
            cb = col + 10'(8 * (e / 8));
            ca = (cb & ~10'(len - 1)) | ((cb + 10'(e % 8)) & 10'(len - 1));
            bus(1'b1, swp_pkg::OFS_MEM_ADDR, {19'h0, b, ca});
            if (e % 8 < len)
                rd(swp_pkg::OFS_MEM_DATA, {24'h0, em[{b, ca}]}, 1'b1, "mem_data");
        end
    endtask
    ////////////////////////////////////////
    initial
    begin
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HWDATA = 32'h0;
        RESET_N = 1'b0;
        void'($urandom(32'he436ce6a));
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        rd(swp_pkg::OFS_CFG, swp_pkg::CFG_RST, 1'b1, "cfg reset");
        rd(swp_pkg::OFS_WR_COUNT, 32'h0, 1'b1, "count reset");
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0, 1'b1, "unmapped");
        bus(1'b1, swp_pkg::OFS_STATUS, 32'hffff_ffff);
        rd(swp_pkg::OFS_STATUS, 32'h0, 1'b1, "status reset");
        $display("test registers done");
        u_ctl.cmd(swp_pkg::CMD_ACT, 3'h1, 14'h0);
        burst(3'h1, 10'h3, 1'b0, 1'b0, 1, 8, 8, 1'b0);
        burst(3'h1, 10'h3, 1'b0, 1'b0, 1, 8, 8, 1'b1);
        rd(swp_pkg::OFS_STATUS, 32'h2, 1'b1, "row open");
        $display("test fixed eight and mask done");
        u_ctl.cmd(swp_pkg::CMD_ACT, 3'h2, 14'h0);
        burst(3'h2, 10'h10, 1'b0, 1'b0, 2, 16, 8, 1'b0);
        $display("test concatenated done");
        bus(1'b1, swp_pkg::OFS_CFG, 32'h0000_0502);
        u_ctl.cmd(swp_pkg::CMD_ACT, 3'h3, 14'h0);
        burst(3'h3, 10'h2a, 1'b1, 1'b1, 1, 8, 4, 1'b0);
        rd(swp_pkg::OFS_STATUS, 32'h6, 1'b1, "auto precharge");
        $display("test fixed four done");
        bus(1'b1, swp_pkg::OFS_CFG, 32'h0000_0511);
        u_ctl.wl = 6;
        u_ctl.cmd(swp_pkg::CMD_ACT, 3'h4, 14'h0);
        burst(3'h4, 10'h35, 1'b0, 1'b1, 1, 8, 8, 1'b0);
        burst(3'h4, 10'h41, 1'b0, 1'b0, 1, 8, 4, 1'b0);
        $display("test on the fly done");
        u_ctl.cmd(swp_pkg::CMD_PRE, 3'h2, 14'h0);
        rd(swp_pkg::OFS_STATUS, 32'h12, 1'b1, "one bank closed");
        u_ctl.cmd(swp_pkg::CMD_PRE, 3'h5, 14'h400);
        rd(swp_pkg::OFS_STATUS, 32'h0, 1'b1, "all banks closed");
        $display("test precharge done");
        stop_test();
    end
    initial
    begin
        #400000;
        err_total++;
        $display("[FAIL] watchdog expected done seen timeout");
        stop_test();
    end
endmodule
